// *** sim/rx_input_mode_and_rate_config_tb.sv ***
// Testbench for receive input-mode and rate configuration
`timescale 1ns/1ps
`default_nettype none
module rx_input_mode_and_rate_config_tb;
  import rxm_pkg::*;
  localparam int WAIT = 20;
  logic          clock_i, nrst_i, pen, refc, sw_wr, sw_sync, sw_ext, sclk, done, lost, bkup;
  logic          pix_valid, pix_ready, word_valid, word_ready;
  logic [2:0]    strap, pmul, pdiv;
  logic [1:0]    f0, f1;
  logic [7:0]    line_mul;
  rxm_port_cfg_t cfg0, cfg1;
  rxm_pix_t      pix;
  rxm_word_t     word;
  int            error_cnt, num_checks, cyc;

  rxm_top #(.STRAP_WAIT_CYC(WAIT)) DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .power_enable_pin_i(pen), .strap_level_i(strap),
    .reference_clock_in_i(refc), .sw_wr_i(sw_wr), .sw_cfg0_i(cfg0), .sw_cfg1_i(cfg1),
    .sw_sync_clk_i(sw_sync), .sw_ext_clk_i(sw_ext), .pix_i(pix), .pix_valid_i(pix_valid),
    .pix_ready_o(pix_ready),
    .word_o(word), .word_valid_o(word_valid), .word_ready_i(word_ready),
    .input_mode_field0_o(f0), .input_mode_field1_o(f1), .sync_clk_mode_o(sclk),
    .strap_done_o(done), .ref_lost_o(lost), .use_backup_osc_o(bkup),
    .line_mul_o(line_mul), .pclk_mul_o(pmul), .pclk_div_o(pdiv));

  rxm_ser_model u_ser (.clock_i(clock_i), .pix_ready_i(pix_ready), .pix_o(pix),
    .pix_valid_o(pix_valid), .ref_o(refc));

  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // Cut a hang short
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Software write of both port settings
  task automatic swr(input logic [1:0] m0, input logic [1:0] m1, input logic s, input logic lsb);
    cfg0 = '{mode: m0, vc_num: 2'h2, data_type: 6'h2B, lsb_align: lsb};
    cfg1 = '{mode: m1, vc_num: 2'h1, data_type: 6'h2C, lsb_align: 1'b0};
    sw_sync = s;
    sw_wr = 1'b1;
    @(negedge clock_i);
    sw_wr = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask

  task automatic t_strap();
    logic [1:0] m;
    int n;
    for (int l = 0; l < 8; l++) begin
      pen = 1'b0;
      strap = l[2:0];
      repeat (4) @(negedge clock_i);
      chk("done_low", 0, done);
      pen = 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 60) begin
        @(negedge clock_i);
        n++;
      end
      repeat (2) @(negedge clock_i);
      m = (l < 4) ? l[1:0] : 2'h0;
      chk("wait", 1, n >= WAIT && n < WAIT + 8);
      chk("mode0", m, f0);
      chk("mode1", m, f1);
      chk("sync", l == 4, sclk);
    end
  endtask

  // Port 1 always gets a different mode than port 0
  task automatic rate(input logic [1:0] m, input logic s, input int ln, input int ml, input int dv);
    swr(m, m ^ 2'h3, s, 1'b0);
    repeat (50) @(negedge clock_i);
    chk("field0", m, f0);
    chk("field1", m ^ 2'h3, f1);
    chk("line", ln, line_mul);
    chk("pmul", ml, pmul);
    chk("pdiv", dv, pdiv);
  endtask

  task automatic t_ref();
    u_ser.ref_run = 1'b1;
    repeat (10) @(negedge clock_i);
    chk("lost", 0, lost);
    chk("backup", 0, bkup);
    u_ser.ref_run = 1'b0;
    repeat (780) @(negedge clock_i);
    chk("lost_early", 0, lost);
    repeat (40) @(negedge clock_i);
    chk("lost_late", 1, lost);
    chk("backup_late", 1, bkup);
    u_ser.ref_run = 1'b1;
    repeat (10) @(negedge clock_i);
  endtask

  task automatic getw(input rxm_word_t e);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 10) begin
      @(negedge clock_i);
      n++;
    end
    chk("word_valid", 1, word_valid);
    chk("word", e, word);
    @(negedge clock_i);
  endtask

  task automatic t_pix();
    int n;
    swr(RXM_MODE_R10, RXM_MODE_PKT, 1'b0, 1'b1);
    word_ready = 1'b1;
    u_ser.send(1'b0, 1'b1, 1'b1, 12'hABC);
    getw('{2'h2, 6'h2B, 1'b1, 1'b1, 12'h2BC});
    u_ser.send(1'b1, 1'b1, 1'b1, 12'h123);
    repeat (6) @(negedge clock_i);
    chk("drop", 0, word_valid);
    swr(RXM_MODE_R10, RXM_MODE_PKT, 1'b0, 1'b0);
    u_ser.send(1'b0, 1'b1, 1'b1, 12'hABC);
    getw('{2'h2, 6'h2B, 1'b0, 1'b0, 12'h2AF});
    // Fill with the far side stalled, then drain in order
    word_ready = 1'b0;
    n = 0;
    while (pix_ready === 1'b1 && n < 8) begin
      u_ser.send(1'b0, 1'b0, 1'b1, (12'h010 + n[11:0]) << 2);
      repeat (2) @(negedge clock_i);
      n++;
    end
    chk("full", 0, pix_ready);
    chk("depth", 1, n >= RXM_FIFO_DEPTH && n < 8);
    word_ready = 1'b1;
    for (int i = 0; i < n; i++) getw('{2'h2, 6'h2B, 1'b0, 1'b0, 12'h010 + i[11:0]});
    repeat (4) @(negedge clock_i);
    chk("empty", 0, word_valid);
    chk("ser_stall", 0, u_ser.stalls);
  endtask

  // Main sequence
  initial begin
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    nrst_i = 1'b0;
    pen = 1'b0;
    strap = 3'h0;
    sw_wr = 1'b0;
    sw_sync = 1'b0;
    sw_ext = 1'b0;
    cfg0 = '0;
    cfg1 = '0;
    word_ready = 1'b0;
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clock_i);
    chk("lost_rst", 1, lost);
    chk("backup_rst", 1, bkup);
    t_strap();
    rate(RXM_MODE_PKT, 1'b1, 160, 4, 1);
    rate(RXM_MODE_PKT, 1'b0, 10, 1, 4);
    sw_ext = 1'b1;
    rate(RXM_MODE_PKT, 1'b0, 80, 2, 1);
    sw_ext = 1'b0;
    rate(RXM_MODE_R12_HF, 1'b0, 28, 2, 3);
    rate(RXM_MODE_R10, 1'b0, 28, 1, 2);
    rate(RXM_MODE_R12_LF, 1'b0, 28, 1, 1);
    t_ref();
    t_pix();
    results();
  end
endmodule // rx_input_mode_and_rate_config_tb
`default_nettype wire

// *** sim/rxm_ser_model.sv ***
// Remote serializer model: pixel source and reference clock
`timescale 1ns/1ps
`default_nettype none
module rxm_ser_model
  import rxm_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic pix_ready_i,
  output rxm_pix_t  pix_o,
  output logic      pix_valid_o,
  output logic      ref_o
);
  logic       ref_run;
  logic [1:0] sync_last;
  int         stalls;
  // Idle outputs at time zero
  initial begin
    pix_o = '0;
    pix_valid_o = 1'b0;
    ref_o = 1'b0;
    ref_run = 1'b0;
    sync_last = 2'h0;
    stalls = 0;
  end
  // 25 MHz reference, unrelated in phase to the core clock, paused while ref_run is low
  always #20 if (ref_run) ref_o = ~ref_o;
  // One pixel per call, held until taken or until the 50-edge stall limit
  task automatic send(input logic p, input logic hs, input logic vs, input logic [11:0] d);
    int n;
    if ({hs, vs} != sync_last) repeat (10) @(posedge clock_i);
    sync_last = {hs, vs};
    n = 0;
    @(negedge clock_i);
    pix_o = '{port: p, hsync: hs, vsync: vs, data: d};
    pix_valid_o = 1'b1;
    // Hold the pixel until ready is seen at a rising edge, or for at most 50 further rising edges
    @(posedge clock_i);
    while (pix_ready_i !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    if (n == 50) stalls++;
    @(negedge clock_i);
    pix_valid_o = 1'b0;
    pix_o = ~pix_o; // Released bus shows the inverse
  endtask
endmodule // rxm_ser_model
`default_nettype wire

// *** verilog/rxm_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rxm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  // Handshakes; full and empty from the count
  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  // Storage write
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
  // Pointers and count
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rxm_fifo
`default_nettype wire

// *** verilog/rxm_pkg.sv ***
// Package: constants and types for receive input-mode and rate configuration
`default_nettype none
package rxm_pkg;
  // Strap levels decoded from the mode pin
  typedef enum logic [2:0] {
    RXM_STRAP_PKT_ASYNC = 3'h0,
    RXM_STRAP_R12_LF    = 3'h1,
    RXM_STRAP_R12_HF    = 3'h2,
    RXM_STRAP_R10       = 3'h3,
    RXM_STRAP_PKT_SYNC  = 3'h4
  } rxm_strap_t;
  // Two-bit input mode field per port
  localparam logic [1:0] RXM_MODE_PKT    = 2'h0;
  localparam logic [1:0] RXM_MODE_R12_LF = 2'h1;
  localparam logic [1:0] RXM_MODE_R12_HF = 2'h2;
  localparam logic [1:0] RXM_MODE_R10    = 2'h3;
  // Register bit positions that mirror the strap
  localparam int RXM_MODE_REG_OFS    = 'h6D;
  localparam int RXM_MODE_LSB        = 0;
  localparam int RXM_STS_REG_OFS     = 'h04;
  localparam int RXM_STS_CLK_BIT     = 4;
  localparam int RXM_PLL_REG_OFS     = 'h1F;
  localparam int RXM_PLL_CLK_BIT     = 3;
  // Rate multipliers
  localparam int RXM_SYNC_LINE_MUL   = 160;
  localparam int RXM_SYNC_PCLK_MUL   = 4;
  localparam int RXM_SYNC_BC_MUL     = 2;
  localparam int RXM_EXT_LINE_MUL    = 80;
  localparam int RXM_EXT_PCLK_MUL    = 2;
  localparam int RXM_CSI_LINE_MUL    = 10;
  localparam int RXM_CSI_PCLK_DIV    = 4;
  localparam int RXM_RAW_FRAME_BITS  = 28;
  localparam int RXM_ASYNC_BC_KBPS   = 10000;
  localparam int RXM_PKT_MAX_MBPS    = 4160;
  localparam int RXM_SENSOR_MAX_MBPS = 3328;
  localparam int RXM_R12HF_MIN_KHZ   = 37500;
  localparam int RXM_R12HF_MAX_KHZ   = 100000;
  localparam int RXM_R10_MIN_KHZ     = 50000;
  localparam int RXM_R10_MAX_KHZ     = 100000;
  localparam int RXM_R12LF_MIN_KHZ   = 25000;
  localparam int RXM_R12LF_MAX_KHZ   = 50000;
  localparam int RXM_R10_SYNC_GAP    = 10;
  localparam int RXM_STRAP_LEVELS    = 8;
  // Timing
  localparam int RXM_CLK_KHZ         = 40000;
  localparam int RXM_STRAP_WAIT_US   = 1000;
  localparam int RXM_STRAP_WAIT_CYC  = RXM_STRAP_WAIT_US * RXM_CLK_KHZ / 1000;
  localparam int RXM_REF_GAP_US      = 20;
  localparam int RXM_REF_GAP_CYC     = RXM_REF_GAP_US * RXM_CLK_KHZ / 1000;
  localparam int RXM_OSC_KHZ         = 25000;
  localparam int RXM_REF_MIN_KHZ     = 23000;
  localparam int RXM_REF_MAX_KHZ     = 26000;
  localparam int RXM_FIFO_DEPTH      = 4;
  localparam int RXM_RAW_W           = 12;
  // Per-port configuration carried together
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] vc_num;
    logic [5:0] data_type;
    logic       lsb_align;
  } rxm_port_cfg_t;
  // Raw pixel word with sync bits
  typedef struct packed {
    logic                 port;
    logic                 hsync;
    logic                 vsync;
    logic [RXM_RAW_W-1:0] data;
  } rxm_pix_t;
  // Packet header produced from a pixel word
  typedef struct packed {
    logic [1:0]  vc_num;
    logic [5:0]  data_type;
    logic        line_start;
    logic        frame_start;
    logic [11:0] data;
  } rxm_word_t;
endpackage : rxm_pkg
`default_nettype wire

// *** verilog/rxm_top.sv ***
// Receive input-mode, strap and reference clock configuration
`timescale 1ns/1ps
`default_nettype none
module rxm_top
  import rxm_pkg::*;
#(
  parameter int STRAP_WAIT_CYC = RXM_STRAP_WAIT_CYC
) (
  input  wire logic          clock_i,
  input  wire logic          nrst_i,
  input  wire logic          power_enable_pin_i,
  input  wire logic [2:0]    strap_level_i,
  input  wire logic          reference_clock_in_i,
  input  wire logic          sw_wr_i,
  input  wire rxm_port_cfg_t sw_cfg0_i,
  input  wire rxm_port_cfg_t sw_cfg1_i,
  input  wire logic          sw_sync_clk_i,
  input  wire logic          sw_ext_clk_i,
  input  wire rxm_pix_t      pix_i,
  input  wire logic          pix_valid_i,
  output logic               pix_ready_o,
  output rxm_word_t          word_o,
  output logic               word_valid_o,
  input  wire logic          word_ready_i,
  output logic [1:0]         input_mode_field0_o,
  output logic [1:0]         input_mode_field1_o,
  output logic               sync_clk_mode_o,
  output logic               strap_done_o,
  output logic               ref_lost_o,
  output logic               use_backup_osc_o,
  output logic [7:0]         line_mul_o,
  output logic [2:0]         pclk_mul_o,
  output logic [2:0]         pclk_div_o
);
  logic          rst_s1_reg, rst_n;
  logic [1:0]    pen_sync_reg, strap_sync0_reg, strap_sync1_reg, strap_sync2_reg;
  logic [1:0]    ref_sync_reg;
  logic          ref_prev_reg;
  logic [15:0]   wait_reg;
  logic [9:0]    gap_reg;
  rxm_port_cfg_t cfg_reg [2];
  logic          sync_clk_reg;
  logic          ext_clk_reg;
  logic          pix_take;
  rxm_strap_t    strap;
  logic          fifo_in_ready;
  rxm_word_t     fifo_in, fifo_out;
  logic          fifo_out_valid, fifo_out_ready;
  logic          hs_prev_reg, vs_prev_reg;
  logic          raw_ok;

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pen_sync_reg    <= 2'h0;
      ref_sync_reg    <= 2'h0;
      strap_sync0_reg <= 2'h0;
      strap_sync1_reg <= 2'h0;
      strap_sync2_reg <= 2'h0;
    end else begin
      pen_sync_reg    <= {pen_sync_reg[0], power_enable_pin_i};
      ref_sync_reg    <= {ref_sync_reg[0], reference_clock_in_i};
      strap_sync0_reg <= {strap_sync0_reg[0], strap_level_i[0]};
      strap_sync1_reg <= {strap_sync1_reg[0], strap_level_i[1]};
      strap_sync2_reg <= {strap_sync2_reg[0], strap_level_i[2]};
    end
  end
  assign strap = rxm_strap_t'({strap_sync2_reg[1], strap_sync1_reg[1], strap_sync0_reg[1]});

  // Wait after power enable before strap sample
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg     <= 16'h0000;
      strap_done_o <= 1'b0;
    end else if (!pen_sync_reg[1]) begin
      wait_reg     <= 16'h0000;
      strap_done_o <= 1'b0;
    end else if (!strap_done_o) begin
      if (wait_reg == 16'(STRAP_WAIT_CYC - 1)) strap_done_o <= 1'b1;
      wait_reg <= wait_reg + 16'h0001;
    end
  end

  // Mode registers: strap on sample, software overwrite after
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg[0]   <= '0;
      cfg_reg[1]   <= '0;
      sync_clk_reg <= 1'b0;
      ext_clk_reg  <= 1'b0;
    end else if (pen_sync_reg[1] && !strap_done_o &&
                 wait_reg == 16'(STRAP_WAIT_CYC - 1)) begin
      for (int p = 0; p < 2; p++) begin
        case (strap)
          RXM_STRAP_R12_LF:   cfg_reg[p].mode <= RXM_MODE_R12_LF;
          RXM_STRAP_R12_HF:   cfg_reg[p].mode <= RXM_MODE_R12_HF;
          RXM_STRAP_R10:      cfg_reg[p].mode <= RXM_MODE_R10;
          default:            cfg_reg[p].mode <= RXM_MODE_PKT;
        endcase
      end
      sync_clk_reg <= (strap == RXM_STRAP_PKT_SYNC);
      ext_clk_reg  <= 1'b0; // No strap level selects it
    end else if (sw_wr_i) begin
      cfg_reg[0]   <= sw_cfg0_i;
      cfg_reg[1]   <= sw_cfg1_i;
      sync_clk_reg <= sw_sync_clk_i;
      ext_clk_reg  <= sw_ext_clk_i;
    end
  end

  // Reference edge watchdog and backup oscillator select
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_reg     <= 1'b0;
      gap_reg          <= 10'h000;
      ref_lost_o       <= 1'b1;
      use_backup_osc_o <= 1'b1;
    end else begin
      ref_prev_reg <= ref_sync_reg[1];
      if (ref_prev_reg != ref_sync_reg[1]) begin
        gap_reg          <= 10'h000;
        ref_lost_o       <= 1'b0;
        use_backup_osc_o <= 1'b0;
      end else if (gap_reg == 10'(RXM_REF_GAP_CYC)) begin
        ref_lost_o       <= 1'b1;
        use_backup_osc_o <= 1'b1;
      end else begin
        gap_reg <= gap_reg + 10'h001;
      end
    end
  end

  // Rate selection for port 0 and clock mode
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      line_mul_o <= 8'h00;
      pclk_mul_o <= 3'h0;
      pclk_div_o <= 3'h1;
    end else if (cfg_reg[0].mode == RXM_MODE_PKT && sync_clk_reg) begin
      line_mul_o <= 8'(RXM_SYNC_LINE_MUL);
      pclk_mul_o <= 3'(RXM_SYNC_PCLK_MUL);
      pclk_div_o <= 3'h1;
    end else if (cfg_reg[0].mode == RXM_MODE_PKT && ext_clk_reg) begin
      line_mul_o <= 8'(RXM_EXT_LINE_MUL);
      pclk_mul_o <= 3'(RXM_EXT_PCLK_MUL);
      pclk_div_o <= 3'h1;
    end else if (cfg_reg[0].mode == RXM_MODE_PKT) begin
      line_mul_o <= 8'(RXM_CSI_LINE_MUL);
      pclk_mul_o <= 3'h1;
      pclk_div_o <= 3'(RXM_CSI_PCLK_DIV);
    end else begin
      line_mul_o <= 8'(RXM_RAW_FRAME_BITS);
      pclk_mul_o <= (cfg_reg[0].mode == RXM_MODE_R12_HF) ? 3'h2 : 3'h1;
      pclk_div_o <= (cfg_reg[0].mode == RXM_MODE_R12_LF) ? 3'h1 :
                    (cfg_reg[0].mode == RXM_MODE_R12_HF) ? 3'h3 : 3'h2;
    end
  end

  // Register mirror outputs
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      input_mode_field0_o <= RXM_MODE_PKT;
      input_mode_field1_o <= RXM_MODE_PKT;
      sync_clk_mode_o     <= 1'b0;
    end else begin
      input_mode_field0_o <= cfg_reg[0].mode;
      input_mode_field1_o <= cfg_reg[1].mode;
      sync_clk_mode_o     <= sync_clk_reg;
    end
  end

  // Sync edge tracking for frame and line starts
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hs_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
    end else if (pix_take) begin
      hs_prev_reg <= pix_i.hsync;
      vs_prev_reg <= pix_i.vsync;
    end
  end

  // Raw pixel to CSI-2 word with per-port header
  assign raw_ok = (cfg_reg[pix_i.port].mode != RXM_MODE_PKT);
  assign pix_take = pix_valid_i & pix_ready_o; // Pixel taken per shown ready
  always_comb begin
    fifo_in.vc_num      = cfg_reg[pix_i.port].vc_num;
    fifo_in.data_type   = cfg_reg[pix_i.port].data_type;
    fifo_in.line_start  = pix_i.hsync & ~hs_prev_reg;
    fifo_in.frame_start = pix_i.vsync & ~vs_prev_reg;
    if (cfg_reg[pix_i.port].mode == RXM_MODE_R10 && cfg_reg[pix_i.port].lsb_align) begin
      fifo_in.data = {2'h0, pix_i.data[9:0]};
    end else if (cfg_reg[pix_i.port].mode == RXM_MODE_R10) begin
      fifo_in.data = {2'h0, pix_i.data[11:2]};
    end else begin
      fifo_in.data = pix_i.data;
    end
  end

  rxm_fifo #(.WIDTH($bits(rxm_word_t)), .DEPTH(RXM_FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n),
    .in_data_i   (fifo_in),
    .in_valid_i  (pix_take & raw_ok),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  // Output stage register
  assign fifo_out_ready = !word_valid_o || word_ready_i;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      word_o       <= '0;
      word_valid_o <= 1'b0;
      pix_ready_o  <= 1'b0;
    end else begin
      // Ready drops for a cycle after each push, so it never offers a full buffer
      pix_ready_o <= fifo_in_ready & ~(pix_take & raw_ok);
      if (fifo_out_ready) begin
        word_o       <= fifo_out;
        word_valid_o <= fifo_out_valid;
      end
    end
  end

  // Checks
  a_strap_wait_len: assert property (@(posedge clock_i) disable iff (!rst_n)
    $rose(strap_done_o) |-> wait_reg == 16'(STRAP_WAIT_CYC))
    else $error("strap sampled at wrong time");
  a_sync_line_mul: assert property (@(posedge clock_i) disable iff (!rst_n)
    $past(rst_n) && $past(sync_clk_reg) && $past(cfg_reg[0].mode) == RXM_MODE_PKT |->
    line_mul_o == 8'(RXM_SYNC_LINE_MUL) && pclk_mul_o == 3'h4)
    else $error("sync rates wrong");
  a_csi_ref_rate: assert property (@(posedge clock_i) disable iff (!rst_n)
    $past(rst_n) && !$past(sync_clk_reg) && !$past(ext_clk_reg) &&
    $past(cfg_reg[0].mode) == RXM_MODE_PKT |->
    line_mul_o == 8'h0A && pclk_div_o == 3'h4)
    else $error("csi reference rates wrong");
  a_ref_gap_lost: assert property (@(posedge clock_i) disable iff (!rst_n)
    gap_reg == 10'(RXM_REF_GAP_CYC) && ref_prev_reg == ref_sync_reg[1] |=> ref_lost_o)
    else $error("reference loss missed");
  a_backup_osc: assert property (@(posedge clock_i) disable iff (!rst_n)
    ref_lost_o |-> use_backup_osc_o)
    else $error("backup oscillator not selected");
  a_mode_mirror: assert property (@(posedge clock_i) disable iff (!rst_n)
    sw_wr_i && !(pen_sync_reg[1] && !strap_done_o) ##1 1 ##1 1 |->
    input_mode_field1_o == $past(sw_cfg1_i.mode, 2))
    else $error("software mode not applied");
  a_raw_r10_data: assert property (@(posedge clock_i) disable iff (!rst_n)
    cfg_reg[pix_i.port].mode == RXM_MODE_R10 |-> fifo_in.data[11:10] == 2'h0)
    else $error("ten-bit data not aligned");
  a_fifo_backpr: assert property (@(posedge clock_i) disable iff (!rst_n)
    word_valid_o && !word_ready_i |=> $stable(word_o))
    else $error("output word changed while stalled");
  a_ext_line_mul: assert property (@(posedge clock_i) disable iff (!rst_n)
    $past(rst_n) && !$past(sync_clk_reg) && $past(ext_clk_reg) &&
    $past(cfg_reg[0].mode) == RXM_MODE_PKT |->
    line_mul_o == 8'h50 && pclk_mul_o == 3'h2 && pclk_div_o == 3'h1)
    else $error("external clock rates wrong");
  a_pix_ready_safe: assert property (@(posedge clock_i) disable iff (!rst_n)
    pix_ready_o |-> fifo_in_ready)
    else $error("ready shown while buffer full");
  c_strap_done:  cover property (@(posedge clock_i) disable iff (!rst_n) $rose(strap_done_o));
  c_ref_lost:    cover property (@(posedge clock_i) disable iff (!rst_n) $rose(ref_lost_o));
  c_word_out:    cover property (@(posedge clock_i) disable iff (!rst_n) word_valid_o && word_ready_i);
  c_fifo_full:   cover property (@(posedge clock_i) disable iff (!rst_n) !fifo_in_ready);
  c_ext_mode:    cover property (@(posedge clock_i) disable iff (!rst_n) ext_clk_reg && sw_wr_i);
endmodule : rxm_top
`default_nettype wire
